// File: dv/clock_speed_and_reset_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module clock_speed_and_reset_control_tb;
    import clock_speed_pkg::*;
    // -----------------------------------------------------------------
    // Signals
    // -----------------------------------------------------------------
    logic       clk = 1'b0;     // Oscillator clock.
    logic       rst_b;          // Bench reset.
    logic       ce;             // Clock enable, high except during the frozen-write check.
    sfr_req_s   sfrReq;         // Register request.
    logic [7:0] sfrRdData;      // Read data.
    logic       pinLevel;       // Resolved reset pin.
    logic       resetPinOut;    // Device pin drive.
    logic       resetPinOe;     // Device pin enable.
    logic       watchdogExpire; // Internal sources.
    logic       counterArrayReset;
    logic       timerReset;
    logic       serialFixedMode;
    logic       coreReset;
    logic [7:0] cycleTick;
    logic       cpuDoubleSpeedActive;
    int         n_errors = 0;   // Mismatches seen.
    int         checks = 0;     // Comparisons made.
    int         seed = 32'h0652;
    int         oeCount;        // Cycles the device drove the pin.
    logic       sawReset;       // Core reset seen since last clear.
    logic [7:0] regModel;       // Behavioural copy of the control register.
    logic [7:0] modes [5] = '{8'h00, 8'hfe, 8'h01, 8'hff, 8'h00};

    always #25 clk = ~clk;      // 20 MHz.

    clock_speed_reset clock_speed_reset_i (
        .clk(clk), .rst_b(rst_b), .ce(ce), .sfrReq(sfrReq), .sfrRdData(sfrRdData),
        .resetPinIn(pinLevel), .resetPinOut(resetPinOut), .resetPinOe(resetPinOe),
        .watchdogExpire(watchdogExpire), .counterArrayReset(counterArrayReset),
        .timerReset(timerReset), .serialFixedMode(serialFixedMode), .coreReset(coreReset),
        .cycleTick(cycleTick), .cpuDoubleSpeedActive(cpuDoubleSpeedActive));

    reset_pin_model reset_pin_model_i (
        .clk(clk), .resetPinOut(resetPinOut), .resetPinOe(resetPinOe), .pinLevel(pinLevel));

    // Watches pin drive length and core reset at every rising edge.
    always @(posedge clk) begin
        if (coreReset === 1'b1) sawReset = 1'b1;
        if (resetPinOe === 1'b1) oeCount++;
    end

    // -----------------------------------------------------------------
    // Tasks
    // -----------------------------------------------------------------
    task automatic final_report();
        if (n_errors == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfrReq = '{addr: a, wrData: d, wr: 1'b1, rd: 1'b0};
        if (a == CLOCK_SPEED_CONTROL_ADDR) regModel = d;
        @(negedge clk);
        sfrReq.wr = 1'b0;
    endtask

    task automatic sfr_check(input logic [7:0] a, input string what);
        @(negedge clk);
        sfrReq = '{addr: a, wrData: 8'h00, wr: 1'b0, rd: 1'b1};
        @(negedge clk);
        sfrReq.rd = 1'b0;
        cmp(what, {8'h00, (a == CLOCK_SPEED_CONTROL_ADDR) ? regModel : 8'h00}, {8'h00, sfrRdData});
    endtask

    // Waits, bounded, for the core reset to finish; the register is then clear.
    task automatic wait_release();
        int k;
        for (k = 0; k < 400 && coreReset !== 1'b0; k++) @(negedge clk);
        cmp("core reset release", 16'h0000, {15'h0000, coreReset});
        regModel = 8'h00;
    endtask

    // Period of one user's tick, counted between two ticks.
    task automatic tick_gap(input int i, output int gap);
        int k;
        for (k = 0; k < 40 && cycleTick[i] !== 1'b1; k++) @(negedge clk);
        gap = 0;
        do begin
            @(negedge clk);
            gap++;
        end while (gap < 40 && cycleTick[i] !== 1'b1);
    endtask

    // Expected periods per cycle of user i under register r.
    function automatic int exp_gap(input int i, input logic [7:0] r, input logic sm);
        bit f;
        f = r[CPU_SPEED_BIT] && (i == CPU_SPEED_BIT || !r[i]) && (i != SERIAL_SPEED_BIT || sm);
        return f ? DOUBLE_PERIODS : STANDARD_PERIODS;
    endfunction

    // -----------------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------------
    initial begin
        int g;
        rst_b = 1'b0;
        ce = 1'b1;
        sfrReq = '0;
        watchdogExpire = 1'b0;
        counterArrayReset = 1'b0;
        timerReset = 1'b0;
        serialFixedMode = 1'b0;
        regModel = 8'h00;
        repeat (10) @(negedge clk);
        reset_pin_model_i.release_power();
        repeat (10) @(negedge clk);
        rst_b = 1'b1;
        sfr_check(CLOCK_SPEED_CONTROL_ADDR, "reset value");
        sfr_write(8'h8e, 8'hff);
        sfr_check(8'h8e, "unmapped read");
        modes[4] = 8'($random(seed)) | 8'h01;
        // Speed selects: tick periods of every user under each setting.
        foreach (modes[m]) begin
            serialFixedMode = 1'($random(seed));
            sfr_write(CLOCK_SPEED_CONTROL_ADDR, modes[m]);
            repeat (3) @(negedge clk);
            cmp("cpu speed active", {15'h0, modes[m][0]}, {15'h0, cpuDoubleSpeedActive});
            sfr_check(CLOCK_SPEED_CONTROL_ADDR, "readback");
            repeat (24) @(negedge clk);
            for (int i = 0; i < 8; i++) begin
                tick_gap(i, g);
                cmp("tick period", 16'(exp_gap(i, modes[m], serialFixedMode)), 16'(g));
            end
        end
        // Clock enable low freezes all state, so this write must not land.
        g = int'(regModel);
        ce = 1'b0;
        sfr_write(CLOCK_SPEED_CONTROL_ADDR, 8'h5a);
        ce = 1'b1;
        regModel = 8'(g);
        sfr_check(CLOCK_SPEED_CONTROL_ADDR, "frozen by enable");
        // Bench reset in mid run: standard speed and a clear register after it.
        rst_b = 1'b0;
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        regModel = CLOCK_SPEED_CONTROL_RESET;
        cmp("cpu speed after reset", 16'h0000, {15'h0, cpuDoubleSpeedActive});
        sfr_check(CLOCK_SPEED_CONTROL_ADDR, "reset mid run");
        // Pin pulses just short and just long enough, in both speeds.
        for (int s = 0; s < 2; s++) begin
            sfr_write(CLOCK_SPEED_CONTROL_ADDR, 8'(s));
            repeat (4) @(negedge clk);
            sawReset = 1'b0;
            reset_pin_model_i.press(MIN_RESET_PERIODS - 1);
            repeat (10) @(negedge clk);
            cmp("short pin pulse", 16'h0000, {15'h0, sawReset});
            reset_pin_model_i.press(MIN_RESET_PERIODS);
            repeat (10) @(negedge clk);
            cmp("long pin pulse", 16'h0001, {15'h0, sawReset});
            wait_release();
            sfr_check(CLOCK_SPEED_CONTROL_ADDR, "cleared by pin");
        end
        // Watchdog expiry, with a second expiry inside the pulse.
        sfr_write(CLOCK_SPEED_CONTROL_ADDR, 8'h41);
        oeCount = 0;
        sawReset = 1'b0;
        watchdogExpire = 1'b1;
        @(negedge clk);
        watchdogExpire = 1'b0;
        repeat (40) @(negedge clk);
        watchdogExpire = 1'b1;
        @(negedge clk);
        watchdogExpire = 1'b0;
        cmp("pin drive level", 16'h0003, {14'h0, resetPinOe, resetPinOut});
        wait_release();
        cmp("pin drive released", 16'h0000, {14'h0, resetPinOe, resetPinOut});
        cmp("watchdog pulse length", 16'(WD_PULSE_PERIODS), 16'(oeCount));
        cmp("watchdog core reset", 16'h0001, {15'h0, sawReset});
        // Counter array and timer requests, one after the other.
        for (int n = 0; n < 2; n++) begin
            sfr_write(CLOCK_SPEED_CONTROL_ADDR, 8'h81);
            sawReset = 1'b0;
            if (n == 0) counterArrayReset = 1'b1;
            else timerReset = 1'b1;
            @(negedge clk);
            counterArrayReset = 1'b0;
            timerReset = 1'b0;
            repeat (3) @(negedge clk);
            cmp("internal reset", 16'h0001, {15'h0, sawReset});
            wait_release();
            sfr_check(CLOCK_SPEED_CONTROL_ADDR, "cleared by source");
        end
        final_report();
    end

    // Hang guard, well beyond the expected run.
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        final_report();
    end
endmodule // clock_speed_and_reset_control_tb
`default_nettype wire

// File: dv/reset_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// -----------------------------------------------------------------
// Outside reset circuitry on the reset pin
// -----------------------------------------------------------------
module reset_pin_model (
    // Clock
    input  wire logic clk,
    // Device drive of the reset pin
    input  wire logic resetPinOut,
    input  wire logic resetPinOe,
    // Resolved pin level
    output logic      pinLevel
);
    logic extLevel = 1'b1;  // Held high from power-up until supply is stable.

    // Wired-OR: either party pulls the pin to its active high level.
    assign pinLevel = extLevel | (resetPinOe & resetPinOut);

    // Power and oscillator are stable, so the outside source lets go.
    task automatic release_power();
        @(negedge clk);
        extLevel = 1'b0;
    endtask

    // A warm reset pulse of n oscillator periods, changed at falling edges.
    task automatic press(input int n);
        @(negedge clk);
        extLevel = 1'b1;
        repeat (n) @(negedge clk);
        extLevel = 1'b0;
    endtask
endmodule // reset_pin_model
`default_nettype wire

// File: logic/clock_speed_pkg.sv
`default_nettype none
package clock_speed_pkg;

    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam logic [7:0] CLOCK_SPEED_CONTROL_ADDR  = 8'h8f;  // Special-function address of the control register.
    localparam logic [7:0] CLOCK_SPEED_CONTROL_RESET = 8'h00;  // All speed selects clear after reset.
    localparam logic [7:0] UNMAPPED_READ_DATA        = 8'h00;  // Reads of any other address return zero.

    // Field positions of the control register.
    localparam int unsigned CAN_SPEED_BIT      = 7;
    localparam int unsigned WATCHDOG_SPEED_BIT = 6;
    localparam int unsigned COUNTER_SPEED_BIT  = 5;
    localparam int unsigned SERIAL_SPEED_BIT   = 4;
    localparam int unsigned TIMER_TWO_BIT      = 3;
    localparam int unsigned TIMER_ONE_BIT      = 2;
    localparam int unsigned TIMER_ZERO_BIT     = 1;
    localparam int unsigned CPU_SPEED_BIT      = 0;
    localparam int unsigned NUM_CLOCK_USERS    = 8;

    // ---------------------------------------------------------------
    // Timing, counted in oscillator periods (one clk period each)
    // ---------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS        = 50;   // Oscillator period at 20 MHz.
    localparam int unsigned STANDARD_PERIODS     = 12;   // Oscillator periods per cycle, standard speed.
    localparam int unsigned DOUBLE_PERIODS       = 6;    // Oscillator periods per cycle, double speed.
    localparam int unsigned MIN_RESET_PERIODS    = 24;   // Least pin high time accepted as a warm reset.
    localparam int unsigned WD_PULSE_PERIODS     = 96;   // Length of the pulse driven out after a watchdog expiry.
    localparam int unsigned MIN_RESET_NS         = MIN_RESET_PERIODS * CLK_PERIOD_NS;
    localparam int unsigned WD_PULSE_NS          = WD_PULSE_PERIODS * CLK_PERIOD_NS;
    localparam logic [6:0]  MIN_RESET_COUNT      = 7'((MIN_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [6:0]  WD_PULSE_COUNT       = 7'(WD_PULSE_NS / CLK_PERIOD_NS);

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    // Field view of the control register.
    typedef struct packed {
        logic canSpeedSelect;
        logic watchdogSpeedSelect;
        logic counterArraySpeedSelect;
        logic serialPortSpeedSelect;
        logic timerTwoSpeedSelect;
        logic timerOneSpeedSelect;
        logic timerZeroSpeedSelect;
        logic cpuDoubleSpeed;
    } clock_speed_control_s;

    // Special-function bus request.
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wrData;
        logic       wr;
        logic       rd;
    } sfr_req_s;

    // Reset qualification states.
    typedef enum logic [2:0] {
        RST_IDLE = 3'b001,
        RST_QUAL = 3'b010,
        RST_HELD = 3'b100
    } reset_state_e;

endpackage : clock_speed_pkg
`default_nettype wire

// File: logic/clock_speed_reset.sv
`timescale 1ns/1ps
`default_nettype none
module clock_speed_reset (
    // Clock, reset and clock enable
    input  wire logic                              clk,
    input  wire logic                              rst_b,
    input  wire logic                              ce,
    // Special-function register port
    input  wire clock_speed_pkg::sfr_req_s         sfrReq,
    output logic [7:0]                             sfrRdData,
    // Reset pin, three signals
    input  wire logic                              resetPinIn,
    output logic                                   resetPinOut,
    output logic                                   resetPinOe,
    // Internal reset sources, same clock domain
    input  wire logic                              watchdogExpire,
    input  wire logic                              counterArrayReset,
    input  wire logic                              timerReset,
    // Serial port mode: high in modes 0 and 2
    input  wire logic                              serialFixedMode,
    // Outputs to core and peripherals
    output logic                                   coreReset,
    output logic [clock_speed_pkg::NUM_CLOCK_USERS-1:0] cycleTick,
    output logic                                   cpuDoubleSpeedActive
);
    import clock_speed_pkg::*;

    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    clock_speed_control_s ctrlFf, nxt_ctrl;         // Control register.
    logic [7:0]           nxt_sfrRdData;            // Next read data.
    logic                 div2Ff, nxt_div2;         // Oscillator divided by two.
    logic                 cpuFastFf, nxt_cpuFast;   // CPU speed bit in force.
    logic                 pinMetaFf, pinSyncFf;     // Pin synchroniser.
    reset_state_e         stateFf, nxt_state;       // Reset qualifier state.
    logic [6:0]           rstCntFf, nxt_rstCnt;     // Periods counted in reset.
    logic                 nxt_coreReset;
    logic [6:0]           wdCntFf, nxt_wdCnt;       // Remaining watchdog pulse.
    logic                 nxt_pinOe;
    logic                 internalReq;              // Counter array or timer source; watchdog expiry comes in through the pin.
    logic [NUM_CLOCK_USERS-1:0] fastVec;            // Double-speed select per user.

    // ---------------------------------------------------------------
    // Register port
    // ---------------------------------------------------------------
    // A write lands only at the documented address; a warm reset clears
    // the register too, so software always restarts at standard speed.
    always_comb begin
        nxt_ctrl      = ctrlFf;
        nxt_sfrRdData = sfrRdData;
        if (coreReset) begin
            nxt_ctrl = clock_speed_control_s'(CLOCK_SPEED_CONTROL_RESET);
        end else if (sfrReq.wr && sfrReq.addr == CLOCK_SPEED_CONTROL_ADDR) begin
            nxt_ctrl = clock_speed_control_s'(sfrReq.wrData);
        end
        if (sfrReq.rd) begin
            // Unmapped reads answer zero rather than keep stale data.
            nxt_sfrRdData = (sfrReq.addr == CLOCK_SPEED_CONTROL_ADDR) ? 8'(ctrlFf) : UNMAPPED_READ_DATA;
        end
    end

    // Registers only.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ctrlFf    <= clock_speed_control_s'(CLOCK_SPEED_CONTROL_RESET);
            sfrRdData <= UNMAPPED_READ_DATA;
        end else if (ce) begin
            ctrlFf    <= nxt_ctrl;
            sfrRdData <= nxt_sfrRdData;
        end
    end

    // ---------------------------------------------------------------
    // Speed mode switching
    // ---------------------------------------------------------------
    // The CPU bit is copied only as the divided clock rises, which keeps
    // the switch from clipping a half period of the divided clock.
    always_comb begin
        nxt_div2    = ~div2Ff;
        nxt_cpuFast = cpuFastFf;
        if (!div2Ff) begin
            nxt_cpuFast = ctrlFf.cpuDoubleSpeed;
        end
    end

    // Registers only.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            div2Ff               <= 1'b0;
            cpuFastFf            <= 1'b0;
            cpuDoubleSpeedActive <= 1'b0;
        end else if (ce) begin
            div2Ff               <= nxt_div2;
            cpuFastFf            <= nxt_cpuFast;
            cpuDoubleSpeedActive <= nxt_cpuFast;
        end
    end

    // Per-user fast select. A peripheral runs fast only with the CPU fast
    // and its own bit clear; the serial bit only matters in modes 0 and 2.
    always_comb begin
        fastVec                 = ~8'(ctrlFf) & {NUM_CLOCK_USERS{cpuFastFf}};
        fastVec[CPU_SPEED_BIT]  = cpuFastFf;
        fastVec[SERIAL_SPEED_BIT] = cpuFastFf & ~ctrlFf.serialPortSpeedSelect & serialFixedMode;
    end

    // One cycle-tick generator per clock user.
    for (genvar i = 0; i < NUM_CLOCK_USERS; i++) begin : g_tick
        period_tick #(
            .SLOW (STANDARD_PERIODS),
            .FAST (DOUBLE_PERIODS)
        ) u_tick (
            .clk   (clk),
            .rst_b (rst_b),
            .ce    (ce),
            .fast  (fastVec[i]),
            .tick  (cycleTick[i])
        );
    end

    // ---------------------------------------------------------------
    // Reset pin synchroniser
    // ---------------------------------------------------------------
    // The pin is asynchronous to clk; only the second stage is read.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pinMetaFf <= 1'b0;
            pinSyncFf <= 1'b0;
        end else if (ce) begin
            pinMetaFf <= resetPinIn;
            pinSyncFf <= pinMetaFf;
        end
    end

    // ---------------------------------------------------------------
    // Reset qualification
    // ---------------------------------------------------------------
    assign internalReq = counterArrayReset | timerReset;

    // A pin level counts as reset only after it stood high for the minimum
    // period count; the count is in oscillator periods, not CPU cycles, so
    // the speed mode never changes it. Internal sources bypass the filter
    // and hold the core for the same minimum. Watchdog expiry is seen via
    // its own pulse on the pin, which reaches the rest of the board too.
    always_comb begin
        nxt_state     = stateFf;
        nxt_rstCnt    = rstCntFf;
        unique case (stateFf)
            RST_IDLE: begin
                if (pinSyncFf) begin
                    nxt_state  = RST_QUAL;
                    nxt_rstCnt = 7'h01;
                end else if (internalReq) begin
                    nxt_state  = RST_HELD;
                    nxt_rstCnt = 7'h00;
                end
            end
            RST_QUAL: begin
                if (!pinSyncFf) begin
                    nxt_state = RST_IDLE;  // Pulse too short: ignored.
                end else if (rstCntFf >= MIN_RESET_COUNT - 7'h01) begin
                    nxt_state  = RST_HELD;
                    nxt_rstCnt = MIN_RESET_COUNT;
                end else begin
                    nxt_rstCnt = rstCntFf + 7'h01;
                end
            end
            RST_HELD: begin
                if (rstCntFf < MIN_RESET_COUNT) begin
                    nxt_rstCnt = rstCntFf + 7'h01;
                end else if (!pinSyncFf && !internalReq) begin
                    nxt_state = RST_IDLE;
                end
            end
            default: begin
                nxt_state  = RST_IDLE;
                nxt_rstCnt = 7'h00;
            end
        endcase
        nxt_coreReset = (nxt_state == RST_HELD);
    end

    // Registers only.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stateFf   <= RST_IDLE;
            rstCntFf  <= 7'h00;
            coreReset <= 1'b0;
        end else if (ce) begin
            stateFf   <= nxt_state;
            rstCntFf  <= nxt_rstCnt;
            coreReset <= nxt_coreReset;
        end
    end

    // ---------------------------------------------------------------
    // Watchdog pulse onto the pin
    // ---------------------------------------------------------------
    // An expiry during a running pulse is absorbed; the pulse is not
    // stretched, which keeps its length fixed for outside supervisors.
    always_comb begin
        nxt_wdCnt = wdCntFf;
        if (wdCntFf != 7'h00) begin
            nxt_wdCnt = wdCntFf - 7'h01;
        end else if (watchdogExpire) begin
            nxt_wdCnt = WD_PULSE_COUNT;
        end
        nxt_pinOe = (nxt_wdCnt != 7'h00);
    end

    // Registers only; the pin is driven high while enabled.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wdCntFf     <= 7'h00;
            resetPinOe  <= 1'b0;
            resetPinOut <= 1'b0;
        end else if (ce) begin
            wdCntFf     <= nxt_wdCnt;
            resetPinOe  <= nxt_pinOe;
            resetPinOut <= nxt_pinOe;
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    a_reg_warm_clear: assert property (@(posedge clk) disable iff (!rst_b)
        (ce && coreReset) |=> (8'(ctrlFf) == 8'h00))
        else $error("control register not cleared by warm reset");

    a_cpu_div_edge: assert property (@(posedge clk) disable iff (!rst_b)
        $changed(cpuFastFf) |-> ($past(div2Ff) == 1'b0))
        else $error("CPU speed changed off the divided clock rise");

    a_periph_slow_only: assert property (@(posedge clk) disable iff (!rst_b)
        !cpuFastFf |-> (fastVec == 8'h00))
        else $error("peripheral fast while CPU at standard speed");

    a_serial_mode_gate: assert property (@(posedge clk) disable iff (!rst_b)
        (!serialFixedMode || ctrlFf.serialPortSpeedSelect) |-> !fastVec[SERIAL_SPEED_BIT])
        else $error("serial fast outside modes 0 and 2");

    a_qual_accept: assert property (@(posedge clk) disable iff (!rst_b)
        (ce && stateFf == RST_QUAL && pinSyncFf && rstCntFf == MIN_RESET_COUNT - 7'h01) |=> coreReset)
        else $error("qualified pin reset not accepted");

    a_qual_no_early: assert property (@(posedge clk) disable iff (!rst_b)
        (stateFf == RST_QUAL && rstCntFf < MIN_RESET_COUNT - 7'h01) |=> !coreReset)
        else $error("pin reset accepted before the minimum");

    a_internal_reset: assert property (@(posedge clk) disable iff (!rst_b)
        (ce && stateFf == RST_IDLE && !pinSyncFf && internalReq) |=> coreReset ##1 (!ce || coreReset))
        else $error("internal reset source not accepted");

    a_wd_pulse_load: assert property (@(posedge clk) disable iff (!rst_b)
        (ce && watchdogExpire && wdCntFf == 7'h00) |=> (resetPinOe && resetPinOut && wdCntFf == WD_PULSE_COUNT))
        else $error("watchdog pulse not started at full length");

    a_wd_pulse_end: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(resetPinOe) |-> ($past(wdCntFf) == 7'h01))
        else $error("watchdog pulse ended early");

endmodule // clock_speed_reset
`default_nettype wire

// File: logic/period_tick.sv
`timescale 1ns/1ps
`default_nettype none
module period_tick #(
    parameter int unsigned SLOW = 12,  // Periods per cycle with fast low.
    parameter int unsigned FAST = 6    // Periods per cycle with fast high.
) (
    // Clock and control
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic ce,
    // Mode select and tick
    input  wire logic fast,
    output logic      tick
);

    // ---------------------------------------------------------------
    // Elaboration checks
    // ---------------------------------------------------------------
    // The counter is four bits wide, so longer cycles cannot be served.
    if (FAST < 1 || FAST > SLOW || SLOW > 15) begin : g_bad
        $error("period_tick: FAST and SLOW out of range");
    end

    localparam logic [3:0] SLOW_LAST = 4'(SLOW - 1);  // Last count, standard speed.
    localparam logic [3:0] FAST_LAST = 4'(FAST - 1);  // Last count, double speed.

    logic [3:0] cntFf;     // Position inside the current cycle.
    logic [3:0] nxt_cnt;
    logic       nxt_tick;
    logic [3:0] lastCnt;   // Terminal count for the mode in force.

    // ---------------------------------------------------------------
    // Cycle counter
    // ---------------------------------------------------------------
    // A mode switch mid cycle takes effect at once; if the count already
    // passed the new end it wraps, so no cycle is ever longer than SLOW.
    always_comb begin
        lastCnt  = fast ? FAST_LAST : SLOW_LAST;
        nxt_tick = 1'b0;
        nxt_cnt  = cntFf + 4'h1;
        if (cntFf >= lastCnt) begin
            nxt_cnt  = 4'h0;
            nxt_tick = 1'b1;
        end
    end

    // Registers only; the tick leaves straight from a flip-flop.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cntFf <= 4'h0;
            tick  <= 1'b0;
        end else if (ce) begin
            cntFf <= nxt_cnt;
            tick  <= nxt_tick;
        end
    end

endmodule // period_tick
`default_nettype wire
